/* fmul_pkg.sv */
// Constants, opcodes and the shared Booth multiplier for the dual-pipe multiply unit.
// Assumes one synchronous clock domain; operands arrive already read from the register files.
//
// How it works
// - Floats use 11-bit exponent, 52-bit coefficient.
// - Even elements pipe 0, odd pipe 1.
// - Low slice takes k 0-49, j 0-50.
// - Low slice products give rounding sticky bits.
// - Integer multiply uses low slice for product.
// - Low slice ignores operation type entirely.
// - Middle slices abort on any float exception flag.
// - Upper-middle: k 33-65, j -1 to 16.
// - Lower-middle: k -1 to 32, j 17-65.
// - High slice: k bits 33-65, j bits 17-65.
// - High slice detects zero, NaNs, infinity.
// - Exception flags go to middles and final.
// - Final stage sums pyramid, delivers coefficient, exponent.
// - Final stage raises interrupt toward relay unit.
// - Opcode 064: scalar times scalar float.
// - Opcode 160: scalar times vector elements.
// - Sign is XOR, exponents are added.
// - Booth recode j in three-bit groups.
// - Integer 64x64 gives 128, half selectable.
package fmul_pkg;
    localparam int EXP_W = 11;               // Exponent field width.
    localparam int FRAC_W = 52;              // Coefficient field width.
    localparam int DATA_W = 64;              // Operand and result width.
    localparam int PROD_W = 128;             // Full integer product width.
    localparam logic [13:0] EXP_BIAS = 14'h03FF;
    localparam logic [10:0] EXP_MAX = 11'h7FF;
    localparam logic [63:0] QNAN = 64'h7FF8000000000000;
    localparam int LOW_K_TOP = 49;           // Low slice k bus top bit.
    localparam int LOW_J_TOP = 50;           // Low slice j bus top bit.
    localparam int SPLIT_K = 33;             // k splits between bits 32 and 33.
    localparam int SPLIT_J = 17;             // j splits between bits 16 and 17.
    localparam int PIPE_LAT = 3;             // Capture, slices, final sum.
    localparam int FIFO_DEPTH = 32;          // Result buffer depth.
    localparam int FIFO_MARGIN = PIPE_LAT + 3;
    localparam logic [7:0] OP_FMUL_SS = 8'h34;  // Octal 064.
    localparam logic [7:0] OP_IMUL_SS = 8'h36;  // Octal 066.
    localparam logic [7:0] OP_FMUL_SV = 8'h70;  // Octal 160.
    localparam logic [7:0] OP_FMUL_VV = 8'h71;  // Octal 161.
    localparam logic [7:0] OP_IMUL_VV = 8'h75;  // Octal 165.
    localparam logic [7:0] OP_IMUL_SV = 8'h76;  // Octal 166.

    // Radix-4 Booth product of two unsigned words; two forced zeros sit above bit 63.
    function automatic logic [127:0] booth_mul(input logic [63:0] a, input logic [63:0] b);
        logic [66:0] bx;
        logic [129:0] acc;
        logic [129:0] m;
        logic [2:0] g;
        bx = {2'b00, b, 1'b0};
        acc = '0;
        m = {66'h0, a};
        g = 3'h0;
        for (int i = 0; i < 33; i++) begin
            g = bx[2*i +: 3];
            case (g)
                3'b001, 3'b010: acc = acc + (m << (2*i));
                3'b011: acc = acc + (m << (2*i + 1));
                3'b100: acc = acc - (m << (2*i + 1));
                3'b101, 3'b110: acc = acc - (m << (2*i));
                default: acc = acc;
            endcase
        end
        return acc[127:0];
    endfunction
endpackage

/* fmul_unit.sv */
// Result FIFO and the dual-pipe float and integer multiply unit.
// Assumes the destination drains results with valid/ready and the issuer honours o_ready.
`timescale 1ns/1ps

// Plain FIFO with honest full and empty; the fill level lets the unit stall early.
module result_fifo #(
    parameter int WIDTH = 66,
    parameter int DEPTH = 32
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data,
    output logic [$clog2(DEPTH+1)-1:0] o_count
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);

    // Elaboration refuses a depth that the wrapping pointers cannot serve.
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
        $error("DEPTH must be a power of two of at least 2.");
    end

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [CW-1:0] cnt;
    } fifo_state_t;

    fifo_state_t r;
    fifo_state_t n;
    logic [WIDTH-1:0] mem [DEPTH];  // Storage is kept outside the state struct as an array.
    logic push;
    logic pop;

    assign o_in_ready = (r.cnt != CW'(DEPTH));
    assign o_out_valid = (r.cnt != '0);
    assign o_out_data = mem[r.rp];
    assign o_count = r.cnt;
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    // Pointers and level move together so full and empty never disagree.
    always_comb begin
        n = r;
        if (push) begin
            n.wp = r.wp + 1'b1;
        end
        if (pop) begin
            n.rp = r.rp + 1'b1;
        end
        n.cnt = r.cnt + CW'(push) - CW'(pop);
    end

    // Control state resets; the data array needs no reset.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // Write port of the storage.
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[r.wp] <= i_in_data;
        end
    end
endmodule

// Two identical pipes; each holds the four pyramid slices and a final summation stage.
module fmul_unit #(
    parameter int DEPTH = fmul_pkg::FIFO_DEPTH
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_valid,                      // Operand pair offered.
    output logic o_ready,                          // Unit can take an operand pair.
    input wire logic [7:0] i_opcode,               // Instruction opcode.
    input wire logic i_upper,                      // Integer: return upper half.
    input wire logic i_elem_odd,                   // Element number is odd.
    input wire logic [fmul_pkg::DATA_W-1:0] i_scalar_j_operand,
    input wire logic [fmul_pkg::DATA_W-1:0] i_scalar_k_operand,
    input wire logic [fmul_pkg::DATA_W-1:0] i_vector_j_operand,
    input wire logic [fmul_pkg::DATA_W-1:0] i_vector_k_operand,
    output logic o_valid,                          // Result held for the destination.
    input wire logic i_ready,                      // Destination takes the result.
    output logic [fmul_pkg::DATA_W-1:0] o_result,
    output logic o_result_odd,                     // Result came from pipe 1.
    output logic o_irq                             // Interrupt toward the relay unit.
);
    import fmul_pkg::*;

    localparam int CW = $clog2(DEPTH+1);

    // Elaboration refuses a buffer too small to hold the pairs still in flight.
    if (DEPTH <= FIFO_MARGIN) begin
        $error("DEPTH must exceed the in-flight margin.");
    end

    // One pipe: stage 1 captures operands and exception flags, stage 2 the slices, stage 3 the result.
    typedef struct packed {
        logic v1;
        logic fp1;
        logic up1;
        logic sgn1;
        logic [EXP_W-1:0] ej1;
        logic [EXP_W-1:0] ek1;
        logic [DATA_W-1:0] j1;
        logic [DATA_W-1:0] k1;
        logic [7:0] exc1;            // jz kz jsn ksn jqn kqn jinf kinf.
        logic v2;
        logic fp2;
        logic up2;
        logic sgn2;
        logic [13:0] e2;             // Biased exponent sum, two's complement.
        logic invalid2;
        logic nan2;
        logic inf2;
        logic zero2;
        logic [PROD_W-1:0] pl2;
        logic [PROD_W-1:0] plm2;
        logic [PROD_W-1:0] pum2;
        logic [PROD_W-1:0] ph2;
        logic v3;
        logic irq3;
        logic [DATA_W-1:0] r3;
    } pipe_t;

    typedef struct packed {
        pipe_t [1:0] p;
        logic rdy;
        logic ov;
        logic oodd;
        logic oirq;
        logic [DATA_W-1:0] od;
    } unit_state_t;

    unit_state_t r;
    unit_state_t n;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [DATA_W+1:0] fifo_in_data;
    logic [DATA_W+1:0] fifo_out_data;
    logic [CW-1:0] fifo_count;

    assign o_ready = r.rdy;
    assign o_valid = r.ov;
    assign o_result = r.od;
    assign o_result_odd = r.oodd;
    assign o_irq = r.oirq;
    assign fifo_out_ready = !r.ov || i_ready;
    // Both pipes share a latency and take one pair per cycle, so at most one finishes per cycle.
    assign fifo_in_data = r.p[1].v3 ? {1'b1, r.p[1].irq3, r.p[1].r3} : {1'b0, r.p[0].irq3, r.p[0].r3};

    result_fifo #(.WIDTH(DATA_W + 2), .DEPTH(DEPTH)) u_fifo (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_in_valid(r.p[0].v3 || r.p[1].v3),
        .o_in_ready(fifo_in_ready),
        .i_in_data(fifo_in_data),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(fifo_out_ready),
        .o_out_data(fifo_out_data),
        .o_count(fifo_count)
    );

    // All pipe stages, the stall decision and the output register.
    always_comb begin
        logic known;
        logic fp;
        logic j_vec;
        logic k_vec;
        logic [DATA_W-1:0] jop;
        logic [DATA_W-1:0] kop;
        logic [DATA_W-1:0] jm;
        logic [DATA_W-1:0] km;
        logic [LOW_K_TOP:0] low_k;
        logic [LOW_J_TOP:0] low_j;
        logic abort;
        logic [PROD_W-1:0] sum;
        logic [13:0] e;
        logic [FRAC_W:0] mant;
        logic guard;
        logic sticky;
        known = 1'b0;
        fp = 1'b0;
        j_vec = 1'b0;
        k_vec = 1'b0;
        jop = '0;
        kop = '0;
        jm = '0;
        km = '0;
        low_k = '0;
        low_j = '0;
        abort = 1'b0;
        sum = '0;
        e = '0;
        mant = '0;
        guard = 1'b0;
        sticky = 1'b0;
        n = r;

        // Decode the opcode into operand sources and operation type.
        case (i_opcode)
            OP_FMUL_SS: begin known = 1'b1; fp = 1'b1; end
            OP_FMUL_SV: begin known = 1'b1; fp = 1'b1; k_vec = 1'b1; end
            OP_FMUL_VV: begin known = 1'b1; fp = 1'b1; j_vec = 1'b1; k_vec = 1'b1; end
            OP_IMUL_SS: begin known = 1'b1; end
            OP_IMUL_SV: begin known = 1'b1; k_vec = 1'b1; end
            OP_IMUL_VV: begin known = 1'b1; j_vec = 1'b1; k_vec = 1'b1; end
            default: known = 1'b0;
        endcase
        jop = j_vec ? i_vector_j_operand : i_scalar_j_operand;
        kop = k_vec ? i_vector_k_operand : i_scalar_k_operand;

        for (int p = 0; p < 2; p++) begin
            // Stage 1: even elements to pipe 0, odd to pipe 1; unknown opcodes are dropped.
            n.p[p].v1 = i_valid && r.rdy && known && (i_elem_odd == (p == 1));
            n.p[p].fp1 = fp;
            n.p[p].up1 = i_upper;
            n.p[p].sgn1 = jop[DATA_W-1] ^ kop[DATA_W-1];
            n.p[p].ej1 = jop[DATA_W-2 -: EXP_W];
            n.p[p].ek1 = kop[DATA_W-2 -: EXP_W];
            // A float feeds its coefficient with the hidden one; an integer feeds all 64 bits.
            n.p[p].j1 = fp ? {11'h000, 1'b1, jop[FRAC_W-1:0]} : jop;
            n.p[p].k1 = fp ? {11'h000, 1'b1, kop[FRAC_W-1:0]} : kop;
            // Exponent-zero operands count as zero; denormals are flushed.
            n.p[p].exc1 = {jop[62:52] == '0, kop[62:52] == '0,
                jop[62:52] == EXP_MAX && !jop[51] && jop[50:0] != '0,
                kop[62:52] == EXP_MAX && !kop[51] && kop[50:0] != '0,
                jop[62:52] == EXP_MAX && jop[51],
                kop[62:52] == EXP_MAX && kop[51],
                jop[62:52] == EXP_MAX && jop[51:0] == '0,
                kop[62:52] == EXP_MAX && kop[51:0] == '0};

            // Stage 2: high slice classifies the pair and forwards the result to the others.
            n.p[p].v2 = r.p[p].v1;
            n.p[p].fp2 = r.p[p].fp1;
            n.p[p].up2 = r.p[p].up1;
            n.p[p].sgn2 = r.p[p].sgn1;
            n.p[p].e2 = 14'(r.p[p].ej1) + 14'(r.p[p].ek1) - EXP_BIAS;
            n.p[p].invalid2 = r.p[p].exc1[5] || r.p[p].exc1[4]
                || (r.p[p].exc1[1] && r.p[p].exc1[6]) || (r.p[p].exc1[0] && r.p[p].exc1[7]);
            n.p[p].nan2 = |r.p[p].exc1[5:2];
            n.p[p].inf2 = |r.p[p].exc1[1:0];
            n.p[p].zero2 = |r.p[p].exc1[7:6];
            abort = r.p[p].fp1 && (|r.p[p].exc1);
            jm = r.p[p].j1;
            km = r.p[p].k1;
            // Low slice sees wide buses but no control; its product is type-blind.
            low_k = km[LOW_K_TOP:0];
            low_j = jm[LOW_J_TOP:0];
            n.p[p].pl2 = booth_mul(64'(low_k[SPLIT_K-1:0]), 64'(low_j[SPLIT_J-1:0]));
            // Lower-middle: k below the split with a zero at -1, j from 17 with zeros at 64-65.
            n.p[p].plm2 = abort ? '0 : booth_mul(64'(km[SPLIT_K-1:0]), 64'(jm[63:SPLIT_J]));
            // Upper-middle: k from 33 with zeros at 64-65, j up to the split with a zero at -1.
            n.p[p].pum2 = abort ? '0 : booth_mul(64'(km[63:SPLIT_K]), 64'(jm[SPLIT_J-1:0]));
            // High slice: both operands from the split upward, zeros above bit 63.
            n.p[p].ph2 = booth_mul(64'(km[63:SPLIT_K]), 64'(jm[63:SPLIT_J]));

            // Stage 3: sum the pyramid and build the result.
            sum = r.p[p].pl2 + (r.p[p].plm2 << SPLIT_J) + (r.p[p].pum2 << SPLIT_K)
                + (r.p[p].ph2 << (SPLIT_K + SPLIT_J));
            e = r.p[p].e2;
            if (sum[105]) begin
                mant = {1'b0, sum[104:53]};
                guard = sum[52];
                sticky = |sum[51:0];
                e = e + 14'h0001;
            end else begin
                mant = {1'b0, sum[103:52]};
                guard = sum[51];
                sticky = |sum[50:0];
            end
            // Round to nearest, ties to even.
            mant = mant + 53'(guard && (sticky || mant[0]));
            if (mant[FRAC_W]) begin
                e = e + 14'h0001;
            end
            n.p[p].v3 = r.p[p].v2;
            n.p[p].irq3 = 1'b0;
            if (!r.p[p].fp2) begin
                n.p[p].r3 = r.p[p].up2 ? sum[127:64] : sum[63:0];
            end else if (r.p[p].invalid2) begin
                n.p[p].r3 = QNAN;
                n.p[p].irq3 = 1'b1;
            end else if (r.p[p].nan2) begin
                n.p[p].r3 = QNAN;
            end else if (r.p[p].inf2) begin
                n.p[p].r3 = {r.p[p].sgn2, EXP_MAX, 52'h0};
            end else if (r.p[p].zero2 || e[13] || e == '0) begin
                // Underflow flushes to a signed zero.
                n.p[p].r3 = {r.p[p].sgn2, 63'h0};
            end else if (e >= 14'(EXP_MAX)) begin
                n.p[p].r3 = {r.p[p].sgn2, EXP_MAX, 52'h0};
                n.p[p].irq3 = 1'b1;
            end else begin
                n.p[p].r3 = {r.p[p].sgn2, e[EXP_W-1:0], mant[FRAC_W-1:0]};
            end
        end

        // The pipes never stall, so ready leaves room for every pair already in flight.
        n.rdy = fifo_in_ready && (fifo_count <= CW'(DEPTH - FIFO_MARGIN));

        // Output register reloads whenever it is empty or being taken.
        // Data and pipe tag load only with a real entry, so unwritten storage never reaches the pins.
        if (fifo_out_ready) begin
            n.ov = fifo_out_valid;
            n.oirq = fifo_out_valid && fifo_out_data[DATA_W];
            if (fifo_out_valid) begin
                n.od = fifo_out_data[DATA_W-1:0];
                n.oodd = fifo_out_data[DATA_W+1];
            end
        end
    end

    // Every stage advances on every edge.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end
endmodule

/* fmul_unit_asserts.sv */
// Port-level timing checks for the dual-pipe multiply unit.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module fmul_unit_asserts
    import fmul_pkg::*;
#(
    parameter int DEPTH = 32
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_valid,
    input wire logic o_ready,
    input wire logic [7:0] i_opcode,
    input wire logic i_elem_odd,
    input wire logic o_valid,
    input wire logic i_ready,
    input wire logic [fmul_pkg::DATA_W-1:0] o_result,
    input wire logic o_result_odd,
    input wire logic o_irq
);
    logic take;          // A known opcode is accepted this cycle.
    logic [7:0] fill_r;  // Pairs accepted while the head result waits.
    logic [7:0] fill_nxt;

    // Unknown opcodes start no work, so they are not counted as accepted.
    always_comb begin
        take = i_valid && o_ready && (i_opcode inside {OP_FMUL_SS, OP_IMUL_SS, OP_FMUL_SV, OP_FMUL_VV,
            OP_IMUL_VV, OP_IMUL_SV});
        fill_nxt = (o_valid && !i_ready) ? fill_r + 8'(take) : 8'h00;
    end

    // A stall that is broken clears the count.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            fill_r <= 8'h00;
        end else begin
            fill_r <= fill_nxt;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    rst_quiet_a: assert property ($fell(i_sys_rst) |-> !o_valid && !o_ready && !o_irq && o_result == '0)
        else $error("outputs not quiet at reset release");
    ready_open_a: assert property ($fell(i_sys_rst) |=> o_ready)
        else $error("unit not ready after reset");
    result_hold_a: assert property (o_valid && !i_ready |=> o_valid && $stable(o_result) &&
        $stable(o_irq) && $stable(o_result_odd))
        else $error("result changed while stalled");
    irq_qual_a: assert property (o_irq |-> o_valid)
        else $error("interrupt flag without result");
    issue_lat_a: assert property (take |-> ##[4:5] o_valid)
        else $error("result late");
    no_stray_a: assert property ($rose(o_valid) |-> $past(take, 4) || $past(take, 5))
        else $error("result without accepted pair");
    // A result that opens a burst always reaches the output exactly five edges after its pair was taken.
    pipe_pick_a: assert property ($rose(o_valid) |->
        $past(take, 5) && o_result_odd == $past(i_elem_odd, 5))
        else $error("result from wrong pipe");
    fifo_guard_a: assert property (o_valid && !i_ready && take |-> fill_r < 8'(DEPTH + 3))
        else $error("pair accepted beyond buffer room");
endmodule

bind fmul_unit fmul_unit_asserts #(.DEPTH(DEPTH)) i_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_valid(i_valid),
    .o_ready(o_ready), .i_opcode(i_opcode), .i_elem_odd(i_elem_odd), .o_valid(o_valid), .i_ready(i_ready),
    .o_result(o_result), .o_result_odd(o_result_odd), .o_irq(o_irq));

/* result_sink.sv */
// Destination register file model that takes results.
// Assumes the bench picks the mode: 0 prompt, 1 random, 2 stalled.
`timescale 1ns/1ps
module result_sink (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [1:0] i_mode,
    output logic o_ready
);
    // Ready changes just after the edge; random mode models a busy write port.
    always @(posedge i_clk) begin
        #1;
        if (i_sys_rst || i_mode == 2'h2) begin
            o_ready = 1'b0;
        end else begin
            o_ready = i_mode == 2'h0 || $urandom_range(1, 0) == 1;
        end
    end
endmodule

/* tb.sv */
// Self-checking bench for the multiply unit with a result scoreboard.
// Assumes results return in issue order and unknown opcodes yield nothing.
`timescale 1ns/1ps
module tb;
    import fmul_pkg::*;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_valid = 1'b0;
    logic [7:0] i_opcode = 8'h00;
    logic i_upper = 1'b0;
    logic i_elem_odd = 1'b0;
    logic [63:0] sj = '0, sk = '0, vj = '0, vk = '0, o_result;
    logic o_ready, o_valid, o_result_odd, o_irq, i_ready;
    logic [1:0] sink_mode = 2'h0;
    logic seen_full = 1'b0;  // The unit refused a pair.
    logic [65:0] exp_q[$];   // Expected {irq, odd, result} in issue order.
    int num_errors = 0;
    int total_checks = 0;
    logic [7:0] fops [3] = '{OP_FMUL_SS, OP_FMUL_SV, OP_FMUL_VV};
    logic [7:0] iops [5] = '{OP_IMUL_SS, OP_IMUL_SV, OP_IMUL_VV, 8'h35, 8'hFF};
    logic [63:0] cor_j [9] = '{64'h3FF8000000000000, 64'h7FE0000000000000, 64'h0010000000000000, 64'h0,
        64'h7FF0000000000000, 64'h7FF0000000000000, 64'h7FF0000000000001, 64'h3FF0000000000000, 64'h3FFFFFFFFFFFFFFF};
    logic [63:0] cor_k [9] = '{64'h4000000000000000, 64'h7FE0000000000000, 64'h0010000000000000, 64'hBFF0000000000000,
        64'hC000000000000000, 64'h8000000000000000, 64'h3FF0000000000000, 64'hFFF8000000000123, 64'h3FFFFFFFFFFFFFFF};

    fmul_unit i_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_valid(i_valid), .o_ready(o_ready),
        .i_opcode(i_opcode), .i_upper(i_upper), .i_elem_odd(i_elem_odd), .i_scalar_j_operand(sj),
        .i_scalar_k_operand(sk), .i_vector_j_operand(vj), .i_vector_k_operand(vk), .o_valid(o_valid),
        .i_ready(i_ready), .o_result(o_result), .o_result_odd(o_result_odd), .o_irq(o_irq));
    result_sink i_sink (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_mode(sink_mode), .o_ready(i_ready));

    always #2 i_clk = ~i_clk;

    // Reference product: {irq, result}; denormal inputs count as zero.
    function automatic logic [64:0] fp_ref(input logic [63:0] a, input logic [63:0] b);
        logic s, na, nb, ia, ib, za, zb;
        logic [105:0] p;
        logic [53:0] m;
        int e;
        s = a[63] ^ b[63];
        na = a[62:52] == EXP_MAX && a[51:0] != '0;
        nb = b[62:52] == EXP_MAX && b[51:0] != '0;
        ia = a[62:52] == EXP_MAX && a[51:0] == '0;
        ib = b[62:52] == EXP_MAX && b[51:0] == '0;
        za = a[62:52] == '0;
        zb = b[62:52] == '0;
        if ((na && !a[51]) || (nb && !b[51]) || (ia && zb) || (za && ib)) return {1'b1, QNAN};
        // A quiet NaN operand yields the unit's one quiet NaN pattern, without an interrupt.
        if (na || nb) return {1'b0, QNAN};
        if (ia || ib) return {1'b0, s, EXP_MAX, 52'h0};
        if (za || zb) return {1'b0, s, 63'h0};
        p = {1'b1, a[51:0]} * {1'b1, b[51:0]};
        e = int'(a[62:52]) + int'(b[62:52]) - 1023 + int'(p[105]);
        if (!p[105]) p = p << 1;
        m = {1'b0, p[105:53]} + 54'(p[52] && (p[53] || p[51:0] != '0));
        if (m[53]) e = e + 1;
        if (m[53]) m = m >> 1;
        if (e >= 2047) return {1'b1, s, EXP_MAX, 52'h0};
        if (e <= 0) return {1'b0, s, 63'h0};
        return {1'b0, s, e[10:0], m[51:0]};
    endfunction

    // Random normal operand whose products stay in range.
    function automatic logic [63:0] rfp();
        logic [63:0] r;
        r = {$urandom, $urandom};
        r[62:52] = 11'h380 + 11'($urandom_range(255, 0));
        return r;
    endfunction

    task automatic chk(input logic [65:0] got, input logic [65:0] want);
        total_checks++;
        if (got !== want) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h want=%h", $time, got, want);
        end
    endtask

    // Offers one pair; the unused source gets the inverse so a wrong pick shows.
    task automatic issue(input logic [7:0] op, input logic up, input logic odd, input logic [63:0] a,
        input logic [63:0] b);
        logic jv, kv;
        logic [127:0] ip;
        logic [64:0] fr;
        jv = op inside {OP_FMUL_VV, OP_IMUL_VV};
        kv = jv || op inside {OP_FMUL_SV, OP_IMUL_SV};
        ip = 128'(a) * 128'(b);
        fr = fp_ref(a, b);
        i_opcode = op;
        i_upper = up;
        i_elem_odd = odd;
        sj = jv ? ~a : a;
        vj = jv ? a : ~a;
        sk = kv ? ~b : b;
        vk = kv ? b : ~b;
        i_valid = 1'b1;
        if (op inside {OP_FMUL_SS, OP_FMUL_SV, OP_FMUL_VV}) exp_q.push_back({fr[64], odd, fr[63:0]});
        if (op inside {OP_IMUL_SS, OP_IMUL_SV, OP_IMUL_VV}) exp_q.push_back({1'b0, odd, up ? ip[127:64] : ip[63:0]});
        @(negedge i_clk);
        for (int n = 0; n < 2000 && o_ready !== 1'b1; n++) @(negedge i_clk);
        @(posedge i_clk);
        #1;
    endtask

    // Waits, bounded, until every expected result has left.
    task automatic drain(input string name);
        i_valid = 1'b0;
        for (int n = 0; n < 3000 && exp_q.size() != 0; n++) @(posedge i_clk);
        repeat (8) @(posedge i_clk);
        #1;
        chk(66'(exp_q.size()), 66'h0);
        $display("test %s done", name);
    endtask

    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Each taken result meets the queue head.
    always @(posedge i_clk) begin
        logic [65:0] w;
        if (!i_sys_rst && o_valid === 1'b1 && i_ready === 1'b1) begin
            w = '1;
            if (exp_q.size() > 0) w = exp_q.pop_front();
            chk({2'b00, o_result}, {2'b00, w[63:0]});
            chk({65'h0, o_result_odd}, {65'h0, w[64]});
            chk({65'h0, o_irq}, {65'h0, w[65]});
        end
    end

    // A held offer with ready low means the buffer refused.
    always @(negedge i_clk) begin
        if (i_valid && o_ready === 1'b0 && !i_sys_rst) seen_full = 1'b1;
    end

    // The tests need under a thousand cycles; this span of 25000 cycles is ample.
    initial begin
        #100000;
        num_errors++;
        report_and_stop();
    end

    initial begin
        logic [7:0] op;
        void'($urandom(32'hC3811E67));
        repeat (8) @(posedge i_clk);
        #1;
        i_sys_rst = 1'b0;
        for (int i = 0; i < 27; i++) begin
            issue(fops[i % 3], 1'b0, i[0], cor_j[i / 3], cor_k[i / 3]);
        end
        drain("corners");
        sink_mode = 2'h1;
        repeat (150) issue(fops[$urandom_range(2, 0)], 1'b0, 1'($urandom), rfp(), rfp());
        drain("float");
        issue(OP_IMUL_SS, 1'b1, 1'b0, '1, '1);
        repeat (120) begin
            op = iops[$urandom_range(4, 0)];
            issue(op, 1'($urandom), 1'($urandom), {$urandom, $urandom}, {$urandom, $urandom});
        end
        drain("integer");
        seen_full = 1'b0;
        sink_mode = 2'h2;
        fork
            repeat (45) issue(OP_IMUL_VV, 1'b0, 1'($urandom), {$urandom, $urandom}, 64'h3);
            begin
                repeat (120) @(posedge i_clk);
                #1;
                chk({65'h0, seen_full}, 66'h1);
                sink_mode = 2'h1;
            end
        join
        drain("stall");
        report_and_stop();
    end
endmodule
